// file: src/cts_defines.vh
// Timing and geometry constants for the charge transfer sequencer.
`ifndef CTS_DEFINES_VH
`define CTS_DEFINES_VH
// Clock period in ns.
`define CTS_CLK_NS 10
// Horizontal stages per register.
`define CTS_H_STAGES 1032
// Lines per frame read out.
`define CTS_LINES 1024
// Half-period of the horizontal clock in cycles (25 MHz pixel rate).
`define CTS_H_HALF 2
// Vertical pulse width, ns, and cycles (least, rounded up).
`define CTS_V_PULSE_NS 3000
`define CTS_V_PULSE_CYC ((`CTS_V_PULSE_NS + `CTS_CLK_NS - 1) / `CTS_CLK_NS)
// Photodiode transfer pulse width, ns.
`define CTS_PD_PULSE_NS 5000
`define CTS_PD_PULSE_CYC ((`CTS_PD_PULSE_NS + `CTS_CLK_NS - 1) / `CTS_CLK_NS)
// Line A to line B transfer pulse width, ns.
`define CTS_AB_PULSE_NS 3000
`define CTS_AB_PULSE_CYC ((`CTS_AB_PULSE_NS + `CTS_CLK_NS - 1) / `CTS_CLK_NS)
// Shutter pulse width, ns.
`define CTS_SH_PULSE_NS 25000
`define CTS_SH_PULSE_CYC ((`CTS_SH_PULSE_NS + `CTS_CLK_NS - 1) / `CTS_CLK_NS)
// Horizontal delay after a transfer, ns.
`define CTS_HD_NS 3000
`define CTS_HD_CYC ((`CTS_HD_NS + `CTS_CLK_NS - 1) / `CTS_CLK_NS)
// Sample data width from the front end.
`define CTS_DW 12
// FIFO depth.
`define CTS_FIFO_DEPTH 16
`endif

// file: src/cts_fifo.v
// Parameterised valid/ready FIFO for sampled pixel pairs.
`timescale 1ns/1ps
module cts_fifo #(
   parameter WIDTH = 24,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire             clk_i,
   input  wire             rst_n_i,
   input  wire [WIDTH-1:0] in_data_i,
   input  wire             in_valid_i,
   output wire             in_ready_o,
   output wire [WIDTH-1:0] out_data_o,
   output wire             out_valid_o,
   input  wire             out_ready_i
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wp_r;
   reg [AW-1:0]    rp_r;
   reg [AW:0]      cnt_r;
   wire            push;
   wire            pop;

   // Handshakes on both sides; full and empty come from the count.
   assign in_ready_o  = (cnt_r != DEPTH[AW:0]);
   assign out_valid_o = (cnt_r != {(AW+1){1'b0}});
   assign out_data_o  = mem[rp_r];
   assign push = in_valid_i & in_ready_o;
   assign pop  = out_valid_o & out_ready_i;

   ////////////////////////////////////////////////////////////////////////
   // Storage is written without reset.
   always @(posedge clk_i) begin
      if (push) begin
         mem[wp_r] <= in_data_i;
      end
   end

   // Pointers and fill count.
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wp_r  <= {AW{1'b0}};
         rp_r  <= {AW{1'b0}};
         cnt_r <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wp_r <= wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= rp_r + 1'b1;
         end
         if (push & ~pop) begin
            cnt_r <= cnt_r + 1'b1;
         end else if (pop & ~push) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end
endmodule

// file: src/cts_sequencer.v
// Frame, line and pixel clock sequencer driving an interline CCD.
// Function
// - Vertical phases are driven as complementary pairs; horizontal A phases too, except during the A to B move.
// - Line transfer pulses vertical phase two while A phase one high.
// - Single-line mode shifts only register A to its output.
// - Dual mode moves A into B: A low, B high, phase two low.
// - A phase one returns high before the next line enters A.
// - Dual mode clocks both horizontal registers out together.
// - Binning makes two vertical transfers per register before one readout.
// - Fast dump gate pulses during the transfer of a cleared line.
// - Output reset pulses only after each pixel has been sampled.
// - Substrate pulse empties photodiodes; integration starts on its fall.
// - Exposure spans shutter fall to vertical phase-one transfer fall.
// - Shutter pulse only inside horizontal retrace, never during readout.
// - Exposure set by choosing the retrace line, frame rate unchanged.
// - Front end samples twice per pixel, referenced to dark pixels; the sequencer gives one sample strobe per pixel.
// - Frame transfer applies the high level to vertical phase one.
// - Single-register mode holds B phase one low permanently.
// - Each line gets enough horizontal cycles for all 1032 stages.
`timescale 1ns/1ps
`include "cts_defines.vh"
module cts_sequencer (
   input  wire                    clk_i,
   input  wire                    rst_n_i,
   input  wire                    start_i,
   input  wire                    dual_mode_i,
   input  wire                    bin_mode_i,
   input  wire                    shutter_en_i,
   input  wire [10:0]             shutter_line_i,
   input  wire                    dump_line_i,
   input  wire [`CTS_DW-1:0]      video_a_i,
   input  wire [`CTS_DW-1:0]      video_b_i,
   output reg                     vertical_phase_one_clock_o,
   output reg                     vertical_phase_one_high_o,
   output reg                     vertical_phase_two_clock_o,
   output reg                     horiz_a_phase_one_clock_o,
   output reg                     horiz_b_phase_one_clock_o,
   output reg                     horiz_shared_phase_two_clock_o,
   output reg                     output_reset_clock_o,
   output reg                     line_clear_gate_o,
   output reg                     substrate_shutter_o,
   output reg                     sample_strobe_o,
   output reg                     busy_o,
   output reg  [10:0]             line_index_o,
   output wire [2*`CTS_DW-1:0]    pix_data_o,
   output wire                    pix_valid_o,
   input  wire                    pix_ready_i,
   output reg                     overrun_o
);
   // Sequencer states.
   localparam S_IDLE  = 4'h0;
   localparam S_PD    = 4'h1;
   localparam S_PDGAP = 4'h2;
   localparam S_V2HI  = 4'h3;
   localparam S_V2LO  = 4'h4;
   localparam S_AB    = 4'h5;
   localparam S_ARET  = 4'h6;
   localparam S_HDLY  = 4'h7;
   localparam S_HRUN  = 4'h8;
   localparam S_RETR  = 4'h9;
   localparam S_SHUT  = 4'ha;

   // Pulse lengths, cut to the 16-bit timer on purpose.
   localparam integer LIM_PD = `CTS_PD_PULSE_CYC;
   localparam integer LIM_V  = `CTS_V_PULSE_CYC;
   localparam integer LIM_AB = `CTS_AB_PULSE_CYC;
   localparam integer LIM_SH = `CTS_SH_PULSE_CYC;
   localparam integer LIM_HD = `CTS_HD_CYC;

   // Waiting time compared against a timer value.
   function done_at;
      input [15:0] t;
      input [15:0] lim;
      begin
         done_at = (t >= lim - 16'h0001);
      end
   endfunction

   reg [3:0]  st_r;
   reg [15:0] tmr_r;
   reg [10:0] pix_r;
   reg [1:0]  ph_r;
   reg [10:0] line_r;
   reg        second_r;
   reg        pass_r;
   reg        dump_r;
   reg        shot_r;
   reg [2:0]  smp_r;
   reg        dual_r;
   reg        bin_r;
   // Video inputs run through two flops before use.
   reg [2*`CTS_DW-1:0] vid_m_r;
   reg [2*`CTS_DW-1:0] vid_s_r;
   wire       fifo_ready;

   ////////////////////////////////////////////////////////////////////////
   // Two-stage synchroniser for the digitised video inputs.
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         vid_m_r <= {(2*`CTS_DW){1'b0}};
         vid_s_r <= {(2*`CTS_DW){1'b0}};
      end else begin
         vid_m_r <= {video_b_i, video_a_i};
         vid_s_r <= vid_m_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Main sequencing machine.
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_r     <= S_IDLE;
         tmr_r    <= 16'h0000;
         pix_r    <= 11'h000;
         ph_r     <= 2'h0;
         line_r   <= 11'h000;
         second_r <= 1'b0;
         pass_r   <= 1'b0;
         dump_r   <= 1'b0;
         shot_r   <= 1'b0;
         dual_r   <= 1'b0;
         bin_r    <= 1'b0;
         vertical_phase_one_clock_o     <= 1'b0;
         vertical_phase_one_high_o      <= 1'b0;
         vertical_phase_two_clock_o     <= 1'b1;
         horiz_a_phase_one_clock_o      <= 1'b1;
         horiz_b_phase_one_clock_o      <= 1'b0;
         horiz_shared_phase_two_clock_o <= 1'b0;
         line_clear_gate_o              <= 1'b0;
         substrate_shutter_o            <= 1'b0;
         busy_o                         <= 1'b0;
         line_index_o                   <= 11'h000;
      end else begin
         tmr_r <= tmr_r + 16'h0001;
         case (st_r)
            S_IDLE: begin
               busy_o <= 1'b0;
               if (start_i) begin
                  // Modes are latched per frame, keeping frame rate fixed.
                  dual_r <= dual_mode_i;
                  bin_r  <= bin_mode_i;
                  busy_o <= 1'b1;
                  tmr_r  <= 16'h0000;
                  line_r <= 11'h000;
                  shot_r <= 1'b0;
                  // Phase two drops as phase one rises so the pair stays opposite.
                  vertical_phase_one_clock_o <= 1'b1;
                  vertical_phase_two_clock_o <= 1'b0;
                  vertical_phase_one_high_o  <= 1'b1;
                  st_r <= S_PD;
               end
            end
            S_PD: begin
               // Its falling edge closes the exposure window.
               if (done_at(tmr_r, LIM_PD[15:0])) begin
                  vertical_phase_one_high_o <= 1'b0;
                  tmr_r <= 16'h0000;
                  st_r  <= S_PDGAP;
               end
            end
            S_PDGAP: begin
               if (done_at(tmr_r, LIM_V[15:0])) begin
                  tmr_r    <= 16'h0000;
                  second_r <= 1'b0;
                  pass_r   <= 1'b0;
                  dump_r   <= dump_line_i;
                  st_r     <= S_V2HI;
               end
            end
            S_V2HI: begin
               // Horizontal clocks frozen, A phase one held high.
               horiz_a_phase_one_clock_o      <= 1'b1;
               horiz_shared_phase_two_clock_o <= 1'b0;
               vertical_phase_two_clock_o     <= 1'b1;
               vertical_phase_one_clock_o     <= 1'b0;
               line_clear_gate_o              <= dump_r;
               if (done_at(tmr_r, LIM_V[15:0])) begin
                  tmr_r <= 16'h0000;
                  st_r  <= S_V2LO;
               end
            end
            S_V2LO: begin
               vertical_phase_two_clock_o <= 1'b0;
               vertical_phase_one_clock_o <= 1'b1;
               if (done_at(tmr_r, LIM_V[15:0])) begin
                  tmr_r             <= 16'h0000;
                  line_clear_gate_o <= 1'b0;
                  line_r            <= line_r + 11'h001;
                  if (bin_r && !second_r) begin
                     second_r <= 1'b1;
                     st_r     <= S_V2HI;
                  end else if (dual_r && !pass_r) begin
                     st_r <= S_AB;
                  end else begin
                     st_r <= S_HDLY;
                  end
               end
            end
            S_AB: begin
               horiz_a_phase_one_clock_o      <= 1'b0;
               horiz_b_phase_one_clock_o      <= 1'b1;
               horiz_shared_phase_two_clock_o <= 1'b0;
               if (done_at(tmr_r, LIM_AB[15:0])) begin
                  tmr_r <= 16'h0000;
                  st_r  <= S_ARET;
               end
            end
            S_ARET: begin
               // A must be high again before the next line lands.
               horiz_a_phase_one_clock_o <= 1'b1;
               horiz_b_phase_one_clock_o <= 1'b0;
               if (done_at(tmr_r, LIM_V[15:0])) begin
                  tmr_r    <= 16'h0000;
                  pass_r   <= 1'b1;
                  second_r <= 1'b0;
                  dump_r   <= dump_line_i;
                  st_r     <= S_V2HI;
               end
            end
            S_HDLY: begin
               if (done_at(tmr_r, LIM_HD[15:0])) begin
                  tmr_r <= 16'h0000;
                  pix_r <= 11'h000;
                  ph_r  <= 2'h0;
                  st_r  <= S_HRUN;
               end
            end
            S_HRUN: begin
               // Complementary horizontal clocking; B runs only in dual.
               line_index_o <= line_r;
               if (tmr_r[1:0] == (`CTS_H_HALF - 1)) begin
                  tmr_r <= 16'h0000;
                  ph_r  <= ph_r + 2'h1;
                  if (!ph_r[0]) begin
                     horiz_shared_phase_two_clock_o <= 1'b1;
                     horiz_a_phase_one_clock_o      <= 1'b0;
                     horiz_b_phase_one_clock_o      <= 1'b0;
                  end else begin
                     // Falling phase two moves a packet out.
                     horiz_shared_phase_two_clock_o <= 1'b0;
                     horiz_a_phase_one_clock_o      <= 1'b1;
                     horiz_b_phase_one_clock_o      <= dual_r;
                     pix_r <= pix_r + 11'h001;
                     if (pix_r == (`CTS_H_STAGES - 1)) begin
                        st_r <= S_RETR;
                     end
                  end
               end
            end
            S_RETR: begin
               // Retrace: the only window for the shutter.
               horiz_shared_phase_two_clock_o <= 1'b0;
               horiz_a_phase_one_clock_o      <= 1'b1;
               horiz_b_phase_one_clock_o      <= 1'b0;
               tmr_r <= 16'h0000;
               if (shutter_en_i && !shot_r &&
                   line_r >= shutter_line_i) begin
                  shot_r              <= 1'b1;
                  substrate_shutter_o <= 1'b1;
                  st_r                <= S_SHUT;
               end else if (line_r >= `CTS_LINES) begin
                  st_r <= S_IDLE;
               end else begin
                  second_r <= 1'b0;
                  pass_r   <= 1'b0;
                  dump_r   <= dump_line_i;
                  st_r     <= S_V2HI;
               end
            end
            S_SHUT: begin
               if (done_at(tmr_r, LIM_SH[15:0])) begin
                  substrate_shutter_o <= 1'b0;
                  tmr_r <= 16'h0000;
                  st_r  <= S_RETR;
               end
            end
            default: begin
               st_r <= S_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Per pixel: sample two cycles after phase two falls, then reset node.
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         smp_r                <= 3'h0;
         sample_strobe_o      <= 1'b0;
         output_reset_clock_o <= 1'b0;
         overrun_o            <= 1'b0;
      end else begin
         smp_r <= {smp_r[1:0], (st_r == S_HRUN) &&
                  (tmr_r[1:0] == (`CTS_H_HALF - 1)) && ph_r[0]};
         sample_strobe_o      <= smp_r[1];
         output_reset_clock_o <= smp_r[2];
         if (smp_r[2] && !fifo_ready) begin
            overrun_o <= 1'b1;
         end else if (start_i && st_r == S_IDLE) begin
            overrun_o <= 1'b0;
         end
      end
   end

   // Sampled pixel pairs queue toward the consumer.
   cts_fifo #(
      .WIDTH (2*`CTS_DW),
      .DEPTH (`CTS_FIFO_DEPTH),
      .AW    (4)
   ) u_fifo (
      .clk_i       (clk_i),
      .rst_n_i     (rst_n_i),
      .in_data_i   (vid_s_r),
      .in_valid_i  (smp_r[2]),
      .in_ready_o  (fifo_ready),
      .out_data_o  (pix_data_o),
      .out_valid_o (pix_valid_o),
      .out_ready_i (pix_ready_i)
   );
endmodule

// file: testbench/cts_sequencer_props.sv
// Assertion checker bound to the charge transfer sequencer.
`timescale 1ns/1ps
`include "cts_defines.vh"
module cts_sequencer_props (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic start_i,
   input wire logic busy_o,
   input wire logic vertical_phase_one_clock_o,
   input wire logic vertical_phase_one_high_o,
   input wire logic vertical_phase_two_clock_o,
   input wire logic horiz_a_phase_one_clock_o,
   input wire logic horiz_b_phase_one_clock_o,
   input wire logic horiz_shared_phase_two_clock_o,
   input wire logic output_reset_clock_o,
   input wire logic line_clear_gate_o,
   input wire logic substrate_shutter_o,
   input wire logic sample_strobe_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   localparam int PD_N = `CTS_PD_PULSE_CYC;
   localparam int SH_N = `CTS_SH_PULSE_CYC;
   wire         v1 = vertical_phase_one_clock_o;
   wire         xh = vertical_phase_one_high_o;
   wire         v2 = vertical_phase_two_clock_o;
   wire         ha = horiz_a_phase_one_clock_o;
   wire         hb = horiz_b_phase_one_clock_o;
   wire         h2 = horiz_shared_phase_two_clock_o;
   logic [15:0] xh_cnt_r;
   logic [15:0] sh_cnt_r;
   ////////////////////////////////////////////////////////////////////////////
   // Count how long the transfer level and the shutter pulse have stood.
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         xh_cnt_r <= 16'h0;
         sh_cnt_r <= 16'h0;
      end else begin
         xh_cnt_r <= xh ? xh_cnt_r + 16'h1 : 16'h0;
         sh_cnt_r <= substrate_shutter_o ? sh_cnt_r + 16'h1 : 16'h0;
      end
   end
   // One pixel: strobe shortly after the phase-two fall, then node reset.
   sequence pix_s;
      ##[1:3] sample_strobe_o ##1 output_reset_clock_o;
   endsequence
   chk_start_taken: assert property (
      !busy_o && start_i |=> busy_o && xh && v1) else $error("start lost");
   chk_v_pair: assert property (v1 != v2)
      else $error("vertical phases equal");
   chk_h_pair: assert property (h2 |-> !ha && !hb)
      else $error("horizontal phases overlap");
   chk_v2_holds_a: assert property (v2 |-> ha && !h2)
      else $error("line moved without A high");
   chk_h_stopped: assert property (
      v2 || line_clear_gate_o |-> !h2 && $stable(h2))
      else $error("pixel clock runs in transfer");
   chk_shut_retrace: assert property (
      substrate_shutter_o |-> $stable(h2) && $stable(ha))
      else $error("shutter during readout");
   chk_shut_width: assert property (
      $fell(substrate_shutter_o) |-> sh_cnt_r == SH_N)
      else $error("shutter width wrong");
   chk_xfer_width: assert property (
      $fell(xh) |-> xh_cnt_r == PD_N) else $error("transfer width wrong");
   chk_pix_sample: assert property ($fell(h2) |-> pix_s)
      else $error("pixel not sampled then reset");
endmodule
bind cts_sequencer cts_sequencer_props cts_sequencer_props_i (.*);

// file: testbench/cts_ccd_model.sv
// Behavioural sensor with front end: one charge level per line and output.
`timescale 1ns/1ps
module cts_ccd_model (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        xfer_hi_i,
   input  wire logic        vp2_i,
   input  wire logic        ha1_i,
   input  wire logic        hb1_i,
   input  wire logic        hp2_i,
   input  wire logic        clr_i,
   output var  logic [11:0] vid_a_o,
   output var  logic [11:0] vid_b_o
);
   logic [10:0] line_r;
   logic        vp2_r;
   logic        ab_r;
   logic        hp2_r;
   logic        read_r;
   logic        clr_r;
   logic [11:0] chg;
   // Charge grows linearly with the row; a dumped line carries none.
   assign chg = (clr_r | clr_i) ? 12'h0 :
                12'(line_r) * 12'h3 + 12'h5;
   ////////////////////////////////////////////////////////////////////////////
   // Track the clock edges and move charge packets between registers.
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         {line_r, ab_r, hp2_r, read_r, clr_r} <= '0;
         vp2_r <= 1'b1;
         {vid_a_o, vid_b_o} <= 24'h0;
      end else begin
         vp2_r <= vp2_i;
         ab_r <= hb1_i & ~ha1_i;
         hp2_r <= hp2_i;
         if (vp2_i)
            clr_r <= clr_r | clr_i;
         if (xfer_hi_i) begin
            line_r <= 11'h0;
            read_r <= 1'b1;
         end
         // A line entering A merges with one not yet read out.
         // Phase two dropping at the photodiode transfer moves no line.
         if (vp2_r && !vp2_i && !xfer_hi_i) begin
            line_r <= line_r + 11'h1;
            vid_a_o <= (read_r ? 12'h0 : vid_a_o) + chg;
            read_r <= 1'b0;
            clr_r <= 1'b0;
         end
         // Register A empties into B while phase two is low.
         if (hb1_i && !ha1_i && !hp2_i && !ab_r) begin
            vid_b_o <= vid_a_o;
            vid_a_o <= 12'h0;
         end
         if (hp2_r && !hp2_i)
            read_r <= 1'b1;
      end
   end
endmodule

// file: testbench/cts_sequencer_tb_top.sv
// Self-checking bench: frames in each readout mode against a sensor model.
`timescale 1ns/1ps
`include "cts_defines.vh"
module cts_sequencer_tb_top;
   logic                 clk_i = 1'b0;
   logic                 rst_n_i = 1'b0;
   logic                 start_i = 1'b0;
   logic                 dual_mode_i = 1'b0;
   logic                 bin_mode_i = 1'b0;
   logic                 shutter_en_i = 1'b0;
   logic [10:0]          shutter_line_i = 11'h1;
   logic                 dump_line_i = 1'b0;
   logic                 pix_ready_i = 1'b0;
   logic                 rdy_en = 1'b1;
   logic                 saw_sh = 1'b0;
   wire  [`CTS_DW-1:0]   video_a_i;
   wire  [`CTS_DW-1:0]   video_b_i;
   wire  [2*`CTS_DW-1:0] pix_data_o;
   wire  [10:0]          line_index_o;
   wire                  vertical_phase_one_clock_o, vertical_phase_one_high_o,
      vertical_phase_two_clock_o, horiz_a_phase_one_clock_o,
      horiz_b_phase_one_clock_o, horiz_shared_phase_two_clock_o,
      output_reset_clock_o, line_clear_gate_o, substrate_shutter_o,
      sample_strobe_o, busy_o, pix_valid_o, overrun_o;
   logic [24:0]          exp_q[$];
   int                   n_mismatch = 0;
   int                   compares = 0;
   int                   i;
   ////////////////////////////////////////////////////////////////////////////
   // Clock, design and sensor model.
   always #5 clk_i = ~clk_i;
   cts_sequencer cts_sequencer_i (.*);
   cts_ccd_model cts_ccd_model_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .xfer_hi_i(vertical_phase_one_high_o),
      .vp2_i(vertical_phase_two_clock_o), .ha1_i(horiz_a_phase_one_clock_o),
      .hb1_i(horiz_b_phase_one_clock_o),
      .hp2_i(horiz_shared_phase_two_clock_o), .clr_i(line_clear_gate_o),
      .vid_a_o(video_a_i), .vid_b_o(video_b_i));
   // Random back-pressure on the pixel output, or a full stall.
   always @(posedge clk_i)
      pix_ready_i <= rdy_en & ($urandom % 4 != 0);
   task automatic check(input string what, input logic [23:0] e,
                        input logic [23:0] g);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic give_verdict;
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Each accepted pixel word is compared with the oldest note; B only in dual.
   always @(posedge clk_i) begin : mon
      logic [24:0] e;
      if (substrate_shutter_o === 1'b1)
         saw_sh <= 1'b1;
      if (rst_n_i && pix_valid_o === 1'b1 && pix_ready_i) begin
         e = (exp_q.size() > 0) ? exp_q.pop_front() : 25'h1ffffff;
         check("pixel word", e[24] ? e[23:0] : {12'h0, e[11:0]},
               e[24] ? pix_data_o : {12'h0, pix_data_o[11:0]});
      end
   end
   function automatic logic [11:0] q(input int l);
      return 12'(3 * l + 5);
   endfunction
   // One readout pass delivers a word for every horizontal stage.
   task automatic push(input logic cb, input logic [11:0] b, a);
      repeat (`CTS_H_STAGES) exp_q.push_back({cb, b, a});
   endtask
   task automatic frame(input logic d, input logic b);
      dual_mode_i <= d;
      bin_mode_i <= b;
      start_i <= 1'b1;
      @(posedge clk_i);
      start_i <= 1'b0;
   endtask
   task automatic falls(input int n);
      int   k;
      logic p;
      k = 0;
      p = horiz_shared_phase_two_clock_o;
      for (i = 0; i < 40000 && k < n; i++) begin
         @(negedge clk_i);
         if (p && !horiz_shared_phase_two_clock_o)
            k++;
         p = horiz_shared_phase_two_clock_o;
      end
      if (k < n) begin
         check("phase two falls", 24'(n), 24'(k));
         give_verdict();
      end
   endtask
   task automatic drain;
      for (i = 0; i < 40000 && exp_q.size() > 0; i++)
         @(posedge clk_i);
      if (exp_q.size() > 0) begin
         check("words left", 24'h0, 24'(exp_q.size()));
         give_verdict();
      end
   endtask
   // Reset in mid-run and compare ten output pins with their reset levels.
   task automatic do_reset;
      @(posedge clk_i);
      rst_n_i <= 1'b0;
      repeat (12) @(posedge clk_i);
      @(negedge clk_i);
      check("reset pins", 24'h0c0, 24'({busy_o, vertical_phase_one_clock_o,
         vertical_phase_two_clock_o, horiz_a_phase_one_clock_o,
         horiz_b_phase_one_clock_o, horiz_shared_phase_two_clock_o,
         line_clear_gate_o, substrate_shutter_o, overrun_o,
         pix_valid_o}));
      @(posedge clk_i);
      rst_n_i <= 1'b1;
      exp_q.delete();
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'hbec9));
      do_reset();
      // Single readout with the shutter armed and the second line dumped.
      shutter_en_i <= 1'b1;
      push(1'b0, 12'h0, q(0));
      push(1'b0, 12'h0, 12'h0);
      push(1'b0, 12'h0, q(2));
      frame(1'b0, 1'b0);
      falls(1);
      @(posedge clk_i);
      dump_line_i <= 1'b1;
      falls(`CTS_H_STAGES);
      @(posedge clk_i);
      dump_line_i <= 1'b0;
      drain();
      check("shutter seen", 24'h1, 24'(saw_sh));
      check("line index", 24'h3, 24'(line_index_o));
      shutter_en_i <= 1'b0;
      do_reset();
      // Dual readout: B carries the earlier line of each pair.
      push(1'b1, q(0), q(1));
      push(1'b1, q(2), q(3));
      frame(1'b1, 1'b0);
      drain();
      check("line index", 24'h4, 24'(line_index_o));
      do_reset();
      // Two lines merged in the charge domain before each readout.
      push(1'b0, 12'h0, q(0) + q(1));
      push(1'b0, 12'h0, q(2) + q(3));
      frame(1'b0, 1'b1);
      drain();
      check("line index", 24'h4, 24'(line_index_o));
      do_reset();
      // Dual readout of binned pairs: B holds lines 0 and 1 merged.
      push(1'b1, q(0) + q(1), q(2) + q(3));
      frame(1'b1, 1'b1);
      drain();
      check("line index", 24'h4, 24'(line_index_o));
      do_reset();
      // Stalled output: the buffer fills, refuses, and flags the loss.
      rdy_en <= 1'b0;
      frame(1'b0, 1'b0);
      for (i = 0; i < 5000 && overrun_o !== 1'b1; i++)
         @(negedge clk_i);
      check("overrun", 24'h3, 24'({overrun_o, pix_valid_o}));
      do_reset();
      give_verdict();
   end
endmodule
